// >>> bench/bpm_monitor_tb.sv
/* testbench for bpm_monitor: apb master, tables of level and mode
   cases, then flag, interrupt and reset-cause tests.
   assumes the comparator model and a 10 MHz clock */
`timescale 1ns/1ps
module bpm_monitor_tb import bpm_pkg::*;;
    typedef struct packed {
        logic [1:0] code; logic [15:0] mv; logic below;
    } bpm_row_t;
    typedef struct packed {logic [7:0] ctrl; logic [2:0] outs;} bpm_md_t;
    logic        sys_clk = 1'b0, srst = 1'b1, porRst = 1'b1;
    logic        cfgDefault = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, slv, cmpBelow;
    logic        cmpEnable, cmpHystEnable, slowRcOn, brownoutReset;
    logic        cpuIrq, irq;
    logic [1:0]  cfgThreshold = 2'h2, thresholdSel;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] supplyMv = 16'h1388;
    int          error_cnt = 0, comparisons = 0, cycles = 0, n;
    bpm_row_t rows [5] = '{'{2'h3, 16'h09C4, 1'b0},
        '{2'h2, 16'h09C4, 1'b1}, '{2'h1, 16'h0BB8, 1'b1},
        '{2'h0, 16'h0FA0, 1'b1}, '{2'h1, 16'h0FA0, 1'b0}};
    bpm_md_t modes [4] = '{'{8'h80, 3'h6}, '{8'h84, 3'h5},
        '{8'h04, 3'h0}, '{8'h00, 3'h0}};
    bpm_monitor DUT (.sys_clk, .srst, .porRst, .cmpBelow, .cfgDefault,
        .cfgThreshold, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .thresholdSel, .cmpEnable, .cmpHystEnable,
        .slowRcOn, .brownoutReset, .cpuIrq, .irq);
    bpm_supply_model u_sup (.sys_clk, .supplyMv, .thresholdSel,
        .cmpEnable, .cmpBelow);
    initial forever #50 sys_clk = ~sys_clk;
    task automatic end_sim;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic check(string name, logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic pulse_rst(logic por);
        @(posedge sys_clk);
        srst <= 1'b1;
        porRst <= por;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        porRst <= 1'b0;
    endtask
    // two sync flops plus the flag edge, with margin
    task automatic settle;
        repeat (8) @(posedge sys_clk);
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        porRst <= 1'b0;
        apb(0, ADDR_PWRCTL, 0);
        check("cold", rd[POWER_CONTROL_REGISTER_COLD], 1'b1);
        apb(1, ADDR_PWRCTL, 0);
        apb(0, ADDR_PWRCTL, 0);
        check("cold clr", rd[POWER_CONTROL_REGISTER_COLD], 1'b0);
        apb(0, 12'hFFC, 0);
        check("slverr", slv, 1'b1);
        foreach (rows[i]) begin
            cfgThreshold <= rows[i].code;
            pulse_rst(1'b0);
            check("level", thresholdSel, rows[i].code);
            supplyMv <= rows[i].mv;
            settle();
            apb(0, ADDR_CONTROL, 0);
            check("flag", rd[PMC_EVT_FLAG], rows[i].below);
            check("state", rd[PMC_STATE], rows[i].below);
            supplyMv <= 16'h1388;
            settle();
            apb(0, ADDR_IRQSTAT, 0);
            check("resume", rd[IRQ_RESUME], rows[i].below);
            apb(0, ADDR_CONTROL, 0);
            check("state up", rd[PMC_STATE], 1'b0);
        end
        foreach (modes[i]) begin
            apb(1, ADDR_CONTROL, {24'h0, modes[i].ctrl});
            check("mode", {cmpEnable, cmpHystEnable, slowRcOn},
                modes[i].outs);
        end
        apb(1, ADDR_CONTROL, 32'h80);
        apb(1, ADDR_IRQMASK, 32'h1);
        apb(1, ADDR_IRQEN, 32'h4);
        supplyMv <= 16'h07D0;
        settle();
        check("irq", irq, 1'b1);
        check("cpu gate", cpuIrq, 1'b0);
        apb(1, ADDR_IRQEN, 32'h84);
        check("cpu irq", cpuIrq, 1'b1);
        apb(1, ADDR_IRQMASK, 32'h0);
        check("masked", irq, 1'b0);
        apb(1, ADDR_IRQMASK, 32'h1);
        apb(1, ADDR_IRQSTAT, 32'h1);
        check("irq clr", irq, 1'b0);
        apb(1, ADDR_CONTROL, 32'h80);
        settle();
        apb(0, ADDR_CONTROL, 0);
        check("no reset", rd[PMC_EVT_FLAG], 1'b0);
        check("cpu clr", cpuIrq, 1'b0);
        supplyMv <= 16'h1388;
        settle();
        apb(1, ADDR_CONTROL, 32'h90);
        supplyMv <= 16'h07D0;
        n = 0;
        do @(posedge sys_clk); while (brownoutReset !== 1'b1 && ++n < 20);
        check("bor req", brownoutReset, 1'b1);
        pulse_rst(1'b0);
        apb(0, ADDR_RSTSTAT, 0);
        check("cause", rd[RSR_BOR_CAUSE], 1'b1);
        pulse_rst(1'b0);
        apb(0, ADDR_RSTSTAT, 0);
        check("kept", rd[RSR_BOR_CAUSE], 1'b1);
        pulse_rst(1'b1);
        apb(0, ADDR_RSTSTAT, 0);
        check("por clr", rd[RSR_BOR_CAUSE], 1'b0);
        apb(1, ADDR_CONTROL, 32'h84);
        repeat (200) @(posedge sys_clk);
        apb(0, ADDR_CONTROL, 0);
        check("sampled", rd[PMC_EVT_FLAG], 1'b0);
        end_sim();
    end
endmodule

// >>> bench/bpm_ports_monitor.sv
/* checker on the power monitor ports.
   assumes a bind onto bpm_monitor, one clock domain */
`timescale 1ns/1ps
module bpm_ports_chk (
    input wire logic       sys_clk,       // clock
    input wire logic       srst,          // reset
    input wire logic       porRst,        // power-on reset
    input wire logic       cmpBelow,      // comparator
    input wire logic       psel,          // apb select
    input wire logic       penable,       // apb enable
    input wire logic [1:0] thresholdSel,  // level code
    input wire logic       cmpEnable,     // comparator power
    input wire logic       cmpHystEnable, // hysteresis on
    input wire logic       slowRcOn,      // slow rc on
    input wire logic       brownoutReset, // reset request
    input wire logic       pslverr,       // apb error
    input wire logic       cpuIrq,        // cpu irq
    input wire logic       irq            // status irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst || porRst);
    thr_stable_a: assert property (!srst && !porRst |=>
        $stable(thresholdSel)) else $error("level code moved");
    hyst_excl_a: assert property (cmpHystEnable |->
        !slowRcOn && cmpEnable) else $error("hysteresis in sampling");
    lowpow_en_a: assert property (slowRcOn |-> cmpEnable)
        else $error("slow rc while detection off");
    bor_pulse_a: assert property (brownoutReset |=>
        !brownoutReset) else $error("reset request too long");
    bor_sync_a: assert property (brownoutReset |->
        $past(cmpBelow, 2) || $past(cmpBelow, 3) || $past(cmpBelow, 4))
        else $error("reset request without drop");
    bor_enabled_a: assert property (brownoutReset |->
        $past(cmpEnable)) else $error("reset request while off");
    reset_quiet_a: assert property (disable iff (1'b0)
        srst || porRst |=> !brownoutReset && !irq && !cpuIrq)
        else $error("outputs active after reset");
    slverr_acc_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    cover property (brownoutReset);
    cover property (slowRcOn);
    cover property (cpuIrq && irq);
endmodule

bind bpm_monitor bpm_ports_chk u_chk (.sys_clk, .srst, .porRst,
    .cmpBelow, .psel, .penable, .thresholdSel, .cmpEnable,
    .cmpHystEnable, .slowRcOn, .brownoutReset, .pslverr, .cpuIrq, .irq);

// >>> bench/bpm_supply_model.sv
/* supply comparator model: supply in mV against the chosen level.
   assumes the bench sets the supply; output is registered on sys_clk, the block's own clock */
`timescale 1ns/1ps
module bpm_supply_model (
    input wire logic        sys_clk,      // clock
    input wire logic [15:0] supplyMv,     // supply, mV
    input wire logic [1:0]  thresholdSel, // level code
    input wire logic        cmpEnable,    // comparator power
    output logic            cmpBelow = 1'b0 // high while below
);
    logic [15:0] levelMv;
    always_comb begin
        case (thresholdSel)
            2'h3:    levelMv = 16'h0898;
            2'h2:    levelMv = 16'h0A8C;
            2'h1:    levelMv = 16'h0ED8;
            default: levelMv = 16'h1194;
        endcase
    end
    // unpowered output is garbage, so it toggles
    always @(posedge sys_clk)
        cmpBelow <= cmpEnable ? (supplyMv < levelMv) : !cmpBelow;
endmodule

// >>> common/bpm_pkg.sv
/*
 * Package for the brown-out power monitor: register offsets, bit positions,
 * reset values, threshold codes and sampling-interval timing.
 * Assumes a 10 MHz system clock and an APB master with 32-bit data.
 */
package bpm_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;

    // APB byte addresses: control stands at its printed offset
    localparam logic [11:0] ADDR_CONTROL  = 12'h0AC;
    localparam logic [11:0] ADDR_RSTSTAT  = 12'h0B0;
    localparam logic [11:0] ADDR_PWRCTL   = 12'h0B4;
    localparam logic [11:0] ADDR_IRQSTAT  = 12'h0B8;
    localparam logic [11:0] ADDR_IRQMASK  = 12'h0BC;
    localparam logic [11:0] ADDR_IRQEN    = 12'h0C0;

    // power_monitor_control bit positions
    localparam int unsigned PMC_DETECT_EN = 7;
    localparam int unsigned PMC_RST_SEL   = 4;
    localparam int unsigned PMC_EVT_FLAG  = 3;
    localparam int unsigned PMC_LOW_POWER = 2;
    localparam int unsigned PMC_STATE     = 0;

    localparam int unsigned RSR_BOR_CAUSE = 2;
    localparam int unsigned POWER_CONTROL_REGISTER_COLD     = 4;

    // extended_irq_enable_reg: brown-out enable and global enable bits
    localparam int unsigned IRQEN_BROWNOUT = 2;
    localparam int unsigned IRQEN_GLOBAL   = 7;

    // irq status/mask layout
    localparam int unsigned IRQ_DROP   = 0;
    localparam int unsigned IRQ_RESUME = 1;
    localparam int unsigned IRQ_BROWNOUT_RESET_SELECT  = 2;
    localparam int unsigned IRQ_BITS   = 3;

    // trigger threshold codes
    localparam logic [1:0] THR_2V2 = 2'h3;
    localparam logic [1:0] THR_2V7 = 2'h2;
    localparam logic [1:0] THR_3V8 = 2'h1;
    localparam logic [1:0] THR_4V5 = 2'h0;

    // low-power sampling interval
    localparam int unsigned SAMPLE_US = 12_800;
    localparam int unsigned SAMPLE_CYCLES = SAMPLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SLOWRC_HZ = 10_000;
    localparam int unsigned SLOWRC_DIV = CLK_HZ / SLOWRC_HZ;
    localparam int unsigned SLOWRC_TICKS = SAMPLE_CYCLES / SLOWRC_DIV;

    localparam logic [7:0] PMC_RESET = 8'h00;

    typedef struct packed {
        logic       detectEnable;
        logic       resetSelect;
        logic       lowPower;
        logic [1:0] threshold;
    } bpm_cfg_t;

    typedef enum logic [1:0] {
        MON_OFF,
        MON_CONT,
        MON_SAMPLED
    } bpm_mode_t;

endpackage

// >>> rtl/bpm_monitor.sv
/*
 * Brown-out power monitor: cold-start flag, brown-out flag, brown-out
 * reset request with sticky cause, low-power sampled detection on a slow
 * tick derived from the system clock, APB register slave, interrupt.
 * Assumes the analog comparator output is asynchronous and high while the
 * supply is below the selected level; porRst is true power-on reset only.
 */
`timescale 1ns/1ps

// How it works
// RL1: power-on completion sets cold-start flag
// RL2: two-bit field selects comparator trigger level
// RL3: drop with reset-select 0 sets flag, irq
// RL4: cleared flag stays clear until next crossing
// RL5: supply resume also sets the event flag
// RL6: read-only state bit: drop or resume
// RL7: drop with reset-select 1 requests reset
// RL8: brown-out reset sets the cause bit
// RL9: cause survives all but power-on reset
// RL10: low-power select only acts when enabled
// RL11: low-power mode samples every 12.8 ms
// RL12: low-power mode runs slow RC timer
// RL13: sampled mode compares without hysteresis
// RL14: normal mode monitors continuously
// RL15: irq needs both enables; software clears
// RL16: codes 11,10,01,00 = 2.2,2.7,3.8,4.5 V
// RL17: detect enable switches detection on/off
// RL18: comparator passes two-flop synchroniser
module bpm_monitor
    import bpm_pkg::*;
(
    input  wire logic        sys_clk,       // system clock, 10 MHz
    input  wire logic        srst,          // any reset, active high
    input  wire logic        porRst,        // power-on reset, active high
    input  wire logic        cmpBelow,      // comparator: vdd below level
    input  wire logic        cfgDefault,    // loaded detect enable at reset
    input  wire logic [1:0]  cfgThreshold,  // loaded threshold code
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB write
    input  wire logic [11:0] paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    output logic      [1:0]  thresholdSel,  // level code to comparator
    output logic             cmpEnable,     // comparator power
    output logic             cmpHystEnable, // hysteresis on
    output logic             slowRcOn,      // slow RC oscillator on
    output logic             brownoutReset, // reset request pulse
    output logic             cpuIrq,        // brown-out irq to CPU
    output logic             irq            // masked status interrupt
);

    bpm_cfg_t  cfg, next_cfg;
    logic      eventFlag, next_eventFlag;
    logic      stateBit, next_stateBit;
    logic      borCause, next_borCause;
    logic      coldFlag, next_coldFlag;
    logic [7:0] irqEnReg, next_irqEnReg;
    logic [IRQ_BITS-1:0] irqStat, next_irqStat;
    logic [IRQ_BITS-1:0] irqMask, next_irqMask;
    logic      syncA, syncB, belowSeen, next_belowSeen;
    logic      primed, next_primed;
    logic [15:0] divCnt, next_divCnt;
    logic [15:0] tickCnt, next_tickCnt;
    logic      rstPend, next_rstPend;
    logic [31:0] next_prdata;
    bpm_mode_t mode;
    logic      wrAcc, rdAcc, sample, dropEv, riseEv, decoded;
    logic      next_cpuIrq, next_irq;

    // register decode
    logic      selCtrl, selRstStat, selPwrCtl;
    logic      selIrqStat, selIrqMask, selIrqEn;

    // synchroniser: first stage is read only by the second
    // reset clears both stages so no false edge follows reset
    always_ff @(posedge sys_clk) begin
        if (srst || porRst) begin
            syncA <= 1'b0;
            syncB <= 1'b0;
        end else begin
            syncA <= cmpBelow;  // RL18
            syncB <= syncA;     // RL18
        end
    end

    always_comb begin
        if (!cfg.detectEnable) begin
            mode = MON_OFF;                         // RL17
        end else if (cfg.lowPower) begin
            mode = MON_SAMPLED;                     // RL10
        end else begin
            mode = MON_CONT;                        // RL14
        end
    end

    assign thresholdSel  = cfg.threshold;           // RL2 RL16
    assign cmpHystEnable = (mode == MON_CONT);      // RL13
    assign slowRcOn      = (mode == MON_SAMPLED);   // RL12
    assign cmpEnable     = (mode != MON_OFF);   // RL17

    // slow tick count stands in for the 10 kHz RC
    // leaving sampled mode clears both counts, so the interval restarts
    always_comb begin
        next_divCnt  = divCnt;
        next_tickCnt = tickCnt;
        sample       = 1'b0;
        case (mode)
            MON_CONT: begin
                next_divCnt  = '0;
                next_tickCnt = '0;
                sample       = 1'b1;                // RL14
            end
            MON_SAMPLED: begin
                if (divCnt == 16'(SLOWRC_DIV - 1)) begin
                    next_divCnt = '0;               // RL12
                    if (tickCnt == 16'(SLOWRC_TICKS - 1)) begin
                        next_tickCnt = '0;
                        sample       = 1'b1;        // RL11
                    end else begin
                        next_tickCnt = tickCnt + 16'h0001;
                    end
                end else begin
                    next_divCnt = divCnt + 16'h0001;
                end
            end
            default: begin
                next_divCnt  = '0;
                next_tickCnt = '0;
            end
        endcase
    end

    // crossings only: a held low supply makes no repeat event
    // a low first sample after enable counts as a drop crossing
    always_comb begin
        next_belowSeen = belowSeen;
        next_primed    = primed;
        dropEv         = 1'b0;
        riseEv         = 1'b0;
        if (mode == MON_OFF) begin
            next_primed    = 1'b0;
            next_belowSeen = 1'b0;
        end else if (sample) begin
            next_primed    = 1'b1;
            next_belowSeen = syncB;
            dropEv = syncB && (!belowSeen || !primed);   // RL4
            riseEv = !syncB && belowSeen && primed;      // RL5
        end
    end

    // one-hot decode keeps the write and read paths in step
    assign selCtrl    = (paddr == ADDR_CONTROL);
    assign selRstStat = (paddr == ADDR_RSTSTAT);
    assign selPwrCtl  = (paddr == ADDR_PWRCTL);
    assign selIrqStat = (paddr == ADDR_IRQSTAT);
    assign selIrqMask = (paddr == ADDR_IRQMASK);
    assign selIrqEn   = (paddr == ADDR_IRQEN);
    assign decoded    = selCtrl || selRstStat || selPwrCtl
                     || selIrqStat || selIrqMask || selIrqEn;
    assign wrAcc      = psel && penable && pwrite;
    // read data captured in setup so it stands through the access
    assign rdAcc      = psel && !penable && !pwrite;
    assign pready     = 1'b1;
    // unmapped writes are dropped and unmapped reads give zero
    assign pslverr    = psel && penable && !decoded;

    // control, reset-cause and cold-start bits
    always_comb begin
        next_cfg       = cfg;
        next_eventFlag = eventFlag;
        next_stateBit  = stateBit;
        next_borCause  = borCause;
        next_coldFlag  = coldFlag;
        next_rstPend   = 1'b0;
        if (wrAcc && selCtrl) begin
            next_cfg.detectEnable = pwdata[PMC_DETECT_EN];
            next_cfg.resetSelect  = pwdata[PMC_RST_SEL];
            next_cfg.lowPower     = pwdata[PMC_LOW_POWER];
            next_eventFlag        = pwdata[PMC_EVT_FLAG];     // RL15
        end
        if (wrAcc && selRstStat) begin
            next_borCause = pwdata[RSR_BOR_CAUSE];            // RL9
        end
        if (wrAcc && selPwrCtl) begin
            next_coldFlag = pwdata[POWER_CONTROL_REGISTER_COLD];                // RL1
        end
        // hardware set wins over a clear in the same cycle
        if (dropEv && cfg.resetSelect) begin
            next_rstPend  = 1'b1;                             // RL7
            next_borCause = 1'b1;                             // RL8
        end else if (dropEv) begin
            next_eventFlag = 1'b1;                            // RL3
            next_stateBit  = 1'b1;                            // RL6
        end
        if (riseEv) begin
            next_eventFlag = 1'b1;                            // RL5
            next_stateBit  = 1'b0;                            // RL6
        end
    end

    // interrupt status, mask and enables
    always_comb begin
        next_irqEnReg = irqEnReg;
        next_irqMask  = irqMask;
        next_irqStat  = irqStat;
        if (wrAcc && selIrqStat) begin
            next_irqStat = irqStat & ~pwdata[IRQ_BITS-1:0];
        end
        if (wrAcc && selIrqMask) begin
            next_irqMask = pwdata[IRQ_BITS-1:0];
        end
        if (wrAcc && selIrqEn) begin
            next_irqEnReg = pwdata[7:0];
        end
        // a new event is not lost to a clear in the same cycle
        if (dropEv && cfg.resetSelect) begin
            next_irqStat[IRQ_BROWNOUT_RESET_SELECT] = 1'b1;
        end else if (dropEv) begin
            next_irqStat[IRQ_DROP] = 1'b1;
        end
        if (riseEv) begin
            next_irqStat[IRQ_RESUME] = 1'b1;
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (rdAcc) begin
            case (paddr)
                ADDR_CONTROL: begin
                    next_prdata[PMC_DETECT_EN] = cfg.detectEnable;
                    next_prdata[PMC_RST_SEL]   = cfg.resetSelect;
                    next_prdata[PMC_EVT_FLAG]  = eventFlag;
                    next_prdata[PMC_LOW_POWER] = cfg.lowPower;
                    next_prdata[PMC_STATE]     = stateBit;        // RL6
                end
                ADDR_RSTSTAT: begin
                    next_prdata[RSR_BOR_CAUSE] = borCause;
                end
                ADDR_PWRCTL: begin
                    next_prdata[POWER_CONTROL_REGISTER_COLD] = coldFlag;
                end
                ADDR_IRQSTAT: begin
                    next_prdata[IRQ_BITS-1:0] = irqStat;
                end
                ADDR_IRQMASK: begin
                    next_prdata[IRQ_BITS-1:0] = irqMask;
                end
                ADDR_IRQEN: begin
                    next_prdata[7:0] = irqEnReg;
                end
                default: ;
            endcase
        end
    end

    // cause and cold flag live outside the ordinary reset domain
    always_ff @(posedge sys_clk) begin
        if (porRst) begin
            borCause <= 1'b0;                                     // RL9
            coldFlag <= 1'b1;                                     // RL1
        end else begin
            borCause <= next_borCause;
            coldFlag <= next_coldFlag;
        end
    end

    // control register group
    always_ff @(posedge sys_clk) begin
        if (srst || porRst) begin
            cfg.detectEnable <= cfgDefault;
            cfg.resetSelect  <= PMC_RESET[PMC_RST_SEL];
            cfg.lowPower     <= PMC_RESET[PMC_LOW_POWER];
            cfg.threshold    <= cfgThreshold;                     // RL2
            eventFlag        <= PMC_RESET[PMC_EVT_FLAG];
            stateBit         <= PMC_RESET[PMC_STATE];
            rstPend          <= 1'b0;
        end else begin
            cfg       <= next_cfg;
            eventFlag <= next_eventFlag;
            stateBit  <= next_stateBit;
            rstPend   <= next_rstPend;
        end
    end

    // interrupt group
    always_ff @(posedge sys_clk) begin
        if (srst || porRst) begin
            irqEnReg <= 8'h00;
            irqStat  <= '0;
            irqMask  <= '0;
            cpuIrq   <= 1'b0;
            irq      <= 1'b0;
        end else begin
            irqEnReg <= next_irqEnReg;
            irqStat  <= next_irqStat;
            irqMask  <= next_irqMask;
            cpuIrq   <= next_cpuIrq;
            irq      <= next_irq;
        end
    end

    // crossing detector group
    always_ff @(posedge sys_clk) begin
        if (srst || porRst) begin
            belowSeen <= 1'b0;
            primed    <= 1'b0;
        end else begin
            belowSeen <= next_belowSeen;
            primed    <= next_primed;
        end
    end

    // slow tick timer group
    always_ff @(posedge sys_clk) begin
        if (srst || porRst) begin
            divCnt  <= 16'h0000;
            tickCnt <= 16'h0000;
        end else begin
            divCnt  <= next_divCnt;
            tickCnt <= next_tickCnt;
        end
    end

    // bus read group
    always_ff @(posedge sys_clk) begin
        if (srst || porRst) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    assign brownoutReset = rstPend;                               // RL7

    // request lines are registered so they cannot glitch
    always_comb begin
        next_cpuIrq = eventFlag && irqEnReg[IRQEN_BROWNOUT]
                   && irqEnReg[IRQEN_GLOBAL];                     // RL15
        next_irq    = |(irqStat & irqMask);
    end

endmodule
